//--- rtl/scwp_pkg.sv
// Constants, field positions and lookup tables for the status/config write-protect block.
// Assumes one 100 MHz reference clock and a serial command link framed by an active-low select.
// How it works
// - Volatile three-bit drive code, factory 111
// - Config bit 3 anchors protection top/bottom
// - Orientation bit is retained, one-time programmable
// - Two-bit dummy code maps per read type
// - Write-status needs latch set beforehand
// - Write-status data never alters latch or busy
// - Only 8 or 16 data bits accepted
// - Select rise starts timed write, busy held
// - Status stays readable during timed write
// - Lock clear: latch and bits always writable
// - Lock set, pin high: still writable
// - Lock set, pin low: refuse status writes
// - Hardware lock regardless of arrival order
// - Pin high or four-wire mode leaves hardware lock
// - Four-wire mode or quad disables lock
// - Block program/erase inside protected region
// - Status byte bit order lock..busy
// - Write-enable sets latch; completion clears it
// - Quad enable turns pins into data

package scwp_pkg;

  // ==========================================================
  // Command opcodes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06; // Sets the write latch
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01; // Status/config write

  // ==========================================================
  // Frame lengths in link bits, opcode included
  localparam logic [4:0] BITS_OPCODE      = 5'h08;
  localparam logic [4:0] BITS_STATUS_ONLY = 5'h10;
  localparam logic [4:0] BITS_STATUS_CFG  = 5'h18;
  localparam logic [4:0] BITS_SATURATE    = 5'h1F; // Counter sticks here

  // ==========================================================
  // Status byte layout
  localparam int STAT_BUSY_POS  = 0;
  localparam int STAT_LATCH_POS = 1;
  localparam int STAT_LEVEL_LSB = 2;
  localparam int STAT_QUAD_POS  = 6;
  localparam int STAT_LOCK_POS  = 7;

  // ==========================================================
  // Configuration byte layout
  localparam int CFG_DRIVE_LSB  = 0;
  localparam int CFG_ORIENT_POS = 3;
  localparam int CFG_DUMMY_LSB  = 6;

  // ==========================================================
  // Values after power-up
  localparam logic [2:0] DRIVE_RESET  = 3'h7; // 30 ohm
  localparam logic [1:0] DUMMY_RESET  = 2'h0;
  localparam logic [3:0] LEVEL_RESET  = 4'h0;
  localparam logic       ORIENT_RESET = 1'b0; // Top anchored
  localparam logic [2:0] DRIVE_RSVD_A = 3'h0; // Reserved drive codes
  localparam logic [2:0] DRIVE_RSVD_B = 3'h4;

  // ==========================================================
  // Dummy clock tables, indexed by the dummy code
  localparam logic [3:0] DUMMY_FAST_TBL [4] = '{4'h8, 4'h6, 4'h8, 4'hA};
  localparam logic [3:0] DUMMY_DUAL_TBL [4] = '{4'h4, 4'h6, 4'h8, 4'hA};
  localparam logic [3:0] DUMMY_QUAD_TBL [4] = '{4'h6, 4'h4, 4'h8, 4'hA};

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS         = 10;
  localparam int STATUS_WRITE_TIME_NS  = 40000;
  localparam int STATUS_WRITE_CYCLES   = STATUS_WRITE_TIME_NS / CLK_PERIOD_NS;

endpackage

//--- rtl/scwp_link_if.sv
// Link-side capture results handed from the serial receiver to the register core.
// Assumes the receiver writes these on the link clock and the core reads them only
// after the select line has settled high, when the link clock is quiet.
`timescale 1ns/1ns
interface scwp_link_if;
  logic [4:0]  bit_count; // Bits seen in the current frame
  logic [7:0]  opcode;    // First eight bits
  logic [15:0] data;      // Bits after the opcode, newest at bit 0

  modport rx   (output bit_count, output opcode, output data);
  modport core (input bit_count, input opcode, input data);
endinterface

//--- rtl/scwp_link_rx.sv
// Serial receiver on the link clock: counts and shifts the bits of one framed command.
// Assumes bits are sampled on rising link clock edges and the clock stops between frames.
`timescale 1ns/1ns
module scwp_link_rx
  import scwp_pkg::*;
(
  input wire logic i_sclk,
  input wire logic i_rst_n,
  input wire logic i_cs_n,
  input wire logic i_si,
  scwp_link_if.rx  link
);

  // ==========================================================
  // Frame start marker
  logic fresh_reg; // High until the first edge of a frame

  // Preset by the idle select line; only a constant enters under the preset
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      fresh_reg <= 1'b1;
    end else begin
      fresh_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Bit counter and shifters
  logic [4:0] count_next;  // Saturating increment
  assign count_next = (link.bit_count == BITS_SATURATE) ? BITS_SATURATE : link.bit_count + 5'h01;

  // Counters are not cleared by select rising, so the core can read them
  // after the frame; the first edge of the next frame restarts them instead
  always_ff @(posedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      link.bit_count <= 5'h00;
      link.opcode    <= 8'h00;
      link.data      <= 16'h0000;
    end else if (fresh_reg) begin
      // First bit of a new frame
      link.bit_count <= 5'h01;
      link.opcode    <= {7'h00, i_si};
      link.data      <= 16'h0000;
    end else begin
      link.bit_count <= count_next;
      if (link.bit_count < BITS_OPCODE) begin
        link.opcode <= {link.opcode[6:0], i_si};
      end else begin
        link.data <= {link.data[14:0], i_si};
      end
    end
  end

endmodule

//--- rtl/scwp_top.sv
// Status and configuration registers with write-status command and write protection.
// Assumes the serial link clock is unrelated to I_REF_CLK, the host leaves the link
// clock still for at least four reference cycles after select rises, and the
// non-volatile array presents its stored bits on I_NV_* while reset is released.
`timescale 1ns/1ns
module scwp_top
  import scwp_pkg::*;
#(
  parameter int WRITE_CYCLES = STATUS_WRITE_CYCLES // Length of the timed register write
)(
  input  wire logic       I_REF_CLK,
  input  wire logic       I_RST_N,
  input  wire logic       I_CE,
  input  wire logic       I_SCLK,
  input  wire logic       I_CS_N,
  input  wire logic       I_SI,
  input  wire logic       I_WRITE_PROTECT_PIN_N,
  input  wire logic       I_FOUR_WIRE_CMD_MODE,
  input  wire logic [7:2] I_NV_STATUS,
  input  wire logic       I_NV_ORIENT,
  input  wire logic       I_PE_REQ,
  input  wire logic       I_PE_IN_REGION,
  input  wire logic       I_PE_BUSY,
  input  wire logic       I_PE_DONE,
  output logic      [7:0] O_STATUS_BYTE,
  output logic      [7:0] O_DEVICE_CONFIG_BYTE,
  output logic      [3:0] O_PROTECT_LEVEL_BITS,
  output logic            O_PROTECT_FROM_BOTTOM,
  output logic      [2:0] O_DRIVE_STRENGTH_SEL,
  output logic            O_DRIVE_RESERVED,
  output logic      [3:0] O_DUMMY_FAST,
  output logic      [3:0] O_DUMMY_DUAL_IO,
  output logic      [3:0] O_DUMMY_QUAD_IO,
  output logic            O_QUAD_IO_ENABLE,
  output logic            O_HW_LOCK_MODE,
  output logic            O_SW_LOCK_MODE,
  output logic            O_PE_GRANT,
  output logic            O_PE_BLOCKED,
  output logic            O_NV_WRITE,
  output logic      [7:2] O_NV_STATUS,
  output logic            O_NV_ORIENT
);

  localparam int CNT_W = $clog2(WRITE_CYCLES + 1); // Write timer width

  typedef enum {SCWP_IDLE, SCWP_WRITING} scwp_state_t;

  // ==========================================================
  // Link receiver
  scwp_link_if link (); // Quasi-static capture of the last frame

  scwp_link_rx u_rx (
    .i_sclk  (I_SCLK),
    .i_rst_n (I_RST_N),
    .i_cs_n  (I_CS_N),
    .i_si    (I_SI),
    .link    (link)
  );

  // ==========================================================
  // Pin synchronisers
  logic cs_s1_reg, cs_s2_reg, cs_s3_reg; // Select line stages
  logic wp_s1_reg, wp_s2_reg, wp_s3_reg; // Protect pin stages
  logic cs_high_reg;                     // Settled select level
  logic wp_high_reg;                     // Settled protect pin level

  // Three stages; stage one feeds stage two only
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      {cs_s1_reg, cs_s2_reg, cs_s3_reg} <= 3'h7;
      {wp_s1_reg, wp_s2_reg, wp_s3_reg} <= 3'h7;
    end else if (I_CE) begin
      {cs_s1_reg, cs_s2_reg, cs_s3_reg} <= {I_CS_N, cs_s1_reg, cs_s2_reg};
      {wp_s1_reg, wp_s2_reg, wp_s3_reg} <= {I_WRITE_PROTECT_PIN_N, wp_s1_reg, wp_s2_reg};
    end
  end

  // A change counts once stages two and three agree
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cs_high_reg <= 1'b1;
      wp_high_reg <= 1'b1;
    end else if (I_CE) begin
      if (cs_s2_reg == cs_s3_reg) begin
        cs_high_reg <= cs_s3_reg;
      end
      if (wp_s2_reg == wp_s3_reg) begin
        wp_high_reg <= wp_s3_reg;
      end
    end
  end

  // ==========================================================
  // Register state
  scwp_state_t      state_reg;         // Timed write sequencer
  logic [CNT_W-1:0] timer_reg;         // Cycles left in the timed write
  logic             load_pending_reg;  // Non-volatile bits not yet fetched
  logic             lock_reg;          // Status lock bit
  logic             quad_reg;          // Quad I/O enable
  logic [3:0]       level_reg;         // Protect level bits
  logic             latch_reg;         // Write latch
  logic             busy_reg;          // Busy as seen in the status byte
  logic             orient_reg;        // Protect from bottom, one-time
  logic [1:0]       dummy_reg;         // Dummy clock code
  logic [2:0]       drive_reg;         // Drive strength code
  logic [7:2]       pend_status_reg;   // Status bits awaiting commit
  logic [7:0]       pend_cfg_reg;      // Config byte awaiting commit
  logic             pend_cfg_ok_reg;   // Config byte was sent

  // ==========================================================
  // Frame decode
  wire frame_end   = I_CE && !cs_high_reg && (cs_s2_reg == cs_s3_reg) && cs_s3_reg;
  wire is_write_enable_cmd_op  = link.opcode == OP_WRITE_ENABLE;
  wire is_write_status_cmd_op  = link.opcode == OP_WRITE_STATUS;
  wire len_status  = link.bit_count == BITS_STATUS_ONLY;
  wire len_cfg     = link.bit_count == BITS_STATUS_CFG;
  wire writing     = state_reg == SCWP_WRITING;
  wire timer_done  = writing && (timer_reg == '0);
  wire write_done  = I_CE && timer_done;
  wire [7:0] status_in = len_cfg ? link.data[15:8] : link.data[7:0];
  wire [7:0] cfg_in    = link.data[7:0];

  // Hardware lock whichever of lock bit and low pin came first
  // Quad or four-wire mode turns the pin into data, so no lock
  // Pin high releases it at once
  wire hw_lock     = lock_reg && !wp_high_reg && !quad_reg && !I_FOUR_WIRE_CMD_MODE;

  wire write_enable_cmd_frame  = frame_end && is_write_enable_cmd_op && (link.bit_count == BITS_OPCODE);
  wire write_enable_cmd_ok     = write_enable_cmd_frame && !writing;
  wire write_status_cmd_frame  = frame_end && is_write_status_cmd_op && (len_status || len_cfg);
  wire write_status_cmd_ok     = write_status_cmd_frame && latch_reg && !hw_lock && !writing;
  wire pe_req      = I_CE && I_PE_REQ && !load_pending_reg;
  wire pe_block    = pe_req && I_PE_IN_REGION;
  wire pe_grant    = pe_req && !I_PE_IN_REGION && latch_reg && !writing;
  wire pe_done     = I_CE && I_PE_DONE;

  // ==========================================================
  // Write sequencer: the timed write begins as select rises
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_reg <= SCWP_IDLE;
      timer_reg <= '0;
    end else if (I_CE) begin
      unique case (state_reg)
        SCWP_IDLE: begin
          if (write_status_cmd_ok) begin
            state_reg <= SCWP_WRITING;
            timer_reg <= CNT_W'(WRITE_CYCLES - 1);
          end
        end
        SCWP_WRITING: begin
          if (timer_reg == '0) begin
            state_reg <= SCWP_IDLE;
          end else begin
            timer_reg <= timer_reg - 1'b1;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Pending values, caught when the command is accepted
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pend_status_reg <= 6'h00;
      pend_cfg_reg    <= 8'h00;
      pend_cfg_ok_reg <= 1'b0;
    end else if (I_CE && write_status_cmd_ok) begin
      // Bits 1 and 0 of the shifted byte are dropped here
      pend_status_reg <= status_in[7:2];
      pend_cfg_reg    <= cfg_in;
      pend_cfg_ok_reg <= len_cfg;
    end
  end

  // ==========================================================
  // Status bits: fetched from the array once, then updated on commit
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      load_pending_reg <= 1'b1;
      lock_reg         <= 1'b0;
      quad_reg         <= 1'b0;
      level_reg        <= LEVEL_RESET;
    end else if (I_CE) begin
      if (load_pending_reg) begin
        // Strap-style capture after release, never under reset
        load_pending_reg <= 1'b0;
        lock_reg         <= I_NV_STATUS[STAT_LOCK_POS];
        quad_reg         <= I_NV_STATUS[STAT_QUAD_POS];
        level_reg        <= I_NV_STATUS[STAT_LEVEL_LSB +: 4];
      end else if (write_done) begin
        lock_reg  <= pend_status_reg[STAT_LOCK_POS];
        quad_reg  <= pend_status_reg[STAT_QUAD_POS];
        level_reg <= pend_status_reg[STAT_LEVEL_LSB +: 4];
      end
    end
  end

  // ==========================================================
  // Configuration byte
  // Volatile fields take defaults at every power-up
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      orient_reg <= ORIENT_RESET;
      dummy_reg  <= DUMMY_RESET;
      drive_reg  <= DRIVE_RESET;
    end else if (I_CE) begin
      if (load_pending_reg) begin
        orient_reg <= I_NV_ORIENT;
      end else if (write_done && pend_cfg_ok_reg) begin
        // Once programmed it cannot return to zero
        orient_reg <= orient_reg | pend_cfg_reg[CFG_ORIENT_POS];
        dummy_reg  <= pend_cfg_reg[CFG_DUMMY_LSB +: 2];
        drive_reg  <= pend_cfg_reg[CFG_DRIVE_LSB +: 3];
      end
    end
  end

  // ==========================================================
  // Write latch; a set in the same cycle as a clear wins
  wire latch_clear = write_done || pe_block || pe_done;
  wire latch_next  = write_enable_cmd_ok ? 1'b1 : (latch_clear ? 1'b0 : latch_reg);

  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      latch_reg <= 1'b0;
    end else if (I_CE) begin
      latch_reg <= latch_next;
    end
  end

  // ==========================================================
  // Busy and program/erase handshake outputs
  wire busy_next = (writing && !timer_done) || write_status_cmd_ok || I_PE_BUSY;

  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      busy_reg     <= 1'b0;
      O_PE_GRANT   <= 1'b0;
      O_PE_BLOCKED <= 1'b0;
      O_NV_WRITE   <= 1'b0;
    end else if (I_CE) begin
      busy_reg     <= busy_next;
      O_PE_GRANT   <= pe_grant;
      O_PE_BLOCKED <= pe_block;
      O_NV_WRITE   <= write_done;
    end
  end

  // ==========================================================
  // Decoded views, registered so the pins are clean
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_DUMMY_FAST     <= DUMMY_FAST_TBL[DUMMY_RESET];
      O_DUMMY_DUAL_IO  <= DUMMY_DUAL_TBL[DUMMY_RESET];
      O_DUMMY_QUAD_IO  <= DUMMY_QUAD_TBL[DUMMY_RESET];
      O_DRIVE_RESERVED <= 1'b0;
      O_HW_LOCK_MODE   <= 1'b0;
    end else if (I_CE) begin
      O_DUMMY_FAST     <= DUMMY_FAST_TBL[dummy_reg];
      O_DUMMY_DUAL_IO  <= DUMMY_DUAL_TBL[dummy_reg];
      O_DUMMY_QUAD_IO  <= DUMMY_QUAD_TBL[dummy_reg];
      O_DRIVE_RESERVED <= (drive_reg == DRIVE_RSVD_A) || (drive_reg == DRIVE_RSVD_B);
      O_HW_LOCK_MODE   <= hw_lock;
    end
  end

  // ==========================================================
  // Register views; readable at all times, even mid-write
  assign O_STATUS_BYTE         = {lock_reg, quad_reg, level_reg, latch_reg, busy_reg};
  assign O_DEVICE_CONFIG_BYTE  = {dummy_reg, 2'h0, orient_reg, drive_reg};
  assign O_PROTECT_LEVEL_BITS  = level_reg;
  assign O_PROTECT_FROM_BOTTOM = orient_reg;
  assign O_DRIVE_STRENGTH_SEL  = drive_reg;
  assign O_QUAD_IO_ENABLE      = quad_reg;
  assign O_SW_LOCK_MODE        = !O_HW_LOCK_MODE;
  assign O_NV_STATUS           = {lock_reg, quad_reg, level_reg};
  assign O_NV_ORIENT           = orient_reg;

  // ==========================================================
  // Checks
  sequence s_busy_run;
    O_STATUS_BYTE[STAT_BUSY_POS] [*8];
  endsequence

  property p_write_enable_cmd_sets;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
      write_enable_cmd_ok |=> latch_reg;
  endproperty
  a_write_enable_cmd_sets: assert property (p_write_enable_cmd_sets) else $error("latch not set by write enable");

  property p_need_latch;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
      write_status_cmd_frame && !latch_reg && !writing |=> state_reg == SCWP_IDLE;
  endproperty
  a_need_latch: assert property (p_need_latch) else $error("status write ran without latch");

  property p_hw_refuse;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
      write_status_cmd_frame && hw_lock && !writing |=> state_reg == SCWP_IDLE;
  endproperty
  a_hw_refuse: assert property (p_hw_refuse) else $error("status write ran under hardware lock");

  property p_bad_length;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
      frame_end && is_write_status_cmd_op && !len_status && !len_cfg && !writing |=> state_reg == SCWP_IDLE;
  endproperty
  a_bad_length: assert property (p_bad_length) else $error("odd-length status write ran");

  property p_busy_hold;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
      write_status_cmd_ok |=> s_busy_run;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

  property p_done_clears;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
      write_done && !write_enable_cmd_ok |=> !latch_reg && state_reg == SCWP_IDLE;
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("latch kept after timed write");

  property p_latch_kept;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
      write_status_cmd_ok && !pe_block && !pe_done |=> latch_reg;
  endproperty
  a_latch_kept: assert property (p_latch_kept) else $error("shifted data touched the latch");

  property p_orient_otp;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
      orient_reg && !load_pending_reg |=> orient_reg;
  endproperty
  a_orient_otp: assert property (p_orient_otp) else $error("orientation bit went back");

  property p_short_cfg;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
      write_done && !pend_cfg_ok_reg |=> $stable(O_DEVICE_CONFIG_BYTE);
  endproperty
  a_short_cfg: assert property (p_short_cfg) else $error("short write changed config");

  property p_block_pe;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
      pe_req && I_PE_IN_REGION && !write_enable_cmd_ok |=> O_PE_BLOCKED && !O_PE_GRANT && !latch_reg;
  endproperty
  a_block_pe: assert property (p_block_pe) else $error("protected program not blocked");

  property p_hw_mode;
    @(posedge I_REF_CLK) disable iff (!I_RST_N)
      I_CE && lock_reg && !wp_high_reg && !quad_reg && !I_FOUR_WIRE_CMD_MODE |=> O_HW_LOCK_MODE;
  endproperty
  a_hw_mode: assert property (p_hw_mode) else $error("hardware lock not entered");

endmodule

//--- verification/scwp_host_model.sv
// Host controller model: frames commands on the serial link.
// Assumes the bench calls send_frame between frames only.
`timescale 1ns/1ns
module scwp_host_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_si
);
  // ==========================================================
  // Idle levels: clock still, select high
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si   = 1'b0;
  end

  // ==========================================================
  // One frame, MSB first, 6 ns link clock only inside the frame
  task automatic send_frame(input logic [23:0] bits, input int n);
    o_cs_n = 1'b0;
    #7;
    for (int i = n - 1; i >= 0; i--) begin
      o_si = bits[i];
      #3 o_sclk = 1'b1;
      #3 o_sclk = 1'b0;
    end
    #3 o_cs_n = 1'b1;
    o_si = ~o_si; // Released line, stale value flipped
    #100; // Link quiet while the core picks up the frame
  endtask
endmodule

//--- verification/tb_top.sv
// Self-checking bench: link frames in, register outputs compared.
// Assumes WRITE_CYCLES is shortened to 20 and stored bits read as zero.
`timescale 1ns/1ns
module tb_top;
  import scwp_pkg::*;
  logic       clk, rst_n, wp_n, four, pe_req, pe_reg, sclk, cs_n, si;
  logic [7:0] stat, cfg;
  logic [3:0] dfast, ddual, dquad;
  logic       orient, drsv, hw, blk;
  logic       grt, sw, quad, nvw, nvo, pe_done;
  logic [3:0] lvl;
  logic [2:0] drv;
  logic [5:0] nvs;
  int         mismatches, compares, nv_pulses;
  logic [2:0] drvs [4] = '{3'h1, 3'h4, 3'h2, 3'h0}; // Drive codes tried
  logic       rsv  [4] = '{1'b0, 1'b1, 1'b0, 1'b1}; // Reserved among them
  logic [3:0] ft   [4] = '{4'h8, 4'h6, 4'h8, 4'hA};
  logic [3:0] dt   [4] = '{4'h4, 4'h6, 4'h8, 4'hA};
  logic [3:0] qt   [4] = '{4'h6, 4'h4, 4'h8, 4'hA};

  // ==========================================================
  // Design and host
  scwp_host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si));
  scwp_top #(.WRITE_CYCLES(20)) uut (
    .I_REF_CLK(clk), .I_RST_N(rst_n), .I_CE(1'b1), .I_SCLK(sclk), .I_CS_N(cs_n), .I_SI(si),
    .I_WRITE_PROTECT_PIN_N(wp_n), .I_FOUR_WIRE_CMD_MODE(four), .I_NV_STATUS(6'h00),
    .I_NV_ORIENT(1'b0), .I_PE_REQ(pe_req), .I_PE_IN_REGION(pe_reg), .I_PE_BUSY(1'b0),
    .I_PE_DONE(pe_done), .O_STATUS_BYTE(stat), .O_DEVICE_CONFIG_BYTE(cfg), .O_PROTECT_LEVEL_BITS(lvl),
    .O_PROTECT_FROM_BOTTOM(orient), .O_DRIVE_STRENGTH_SEL(drv), .O_DRIVE_RESERVED(drsv),
    .O_DUMMY_FAST(dfast), .O_DUMMY_DUAL_IO(ddual), .O_DUMMY_QUAD_IO(dquad), .O_QUAD_IO_ENABLE(quad),
    .O_HW_LOCK_MODE(hw), .O_SW_LOCK_MODE(sw), .O_PE_GRANT(grt), .O_PE_BLOCKED(blk), .O_NV_WRITE(nvw),
    .O_NV_STATUS(nvs), .O_NV_ORIENT(nvo));

  // Commit pulses counted mid-cycle, where the registered pulse is settled
  always @(negedge clk) begin
    if (nvw === 1'b1) nv_pulses++;
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // Compare, verdict, bounded wait for the timed write
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic settle();
    int n;
    n = 0;
    @(posedge clk) #1;
    while (stat[0] !== 1'b0) begin
      n++;
      if (n > 200) begin
        mismatches++;
        complete_run();
      end
      @(posedge clk) #1;
    end
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Write enable, then an n-bit write-status frame
  task automatic wsr(input logic [7:0] s, input logic [7:0] c, input int n, input logic acc);
    host.send_frame(24'(OP_WRITE_ENABLE), 8);
    host.send_frame(24'({OP_WRITE_STATUS, s, c} >> (24 - n)), n);
    chk({7'h00, stat[0]}, {7'h00, acc});
    settle();
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    four = 1'b0;
    pe_req = 1'b0;
    pe_reg = 1'b0;
    pe_done = 1'b0;
    mismatches = 0;
    compares = 0;
    nv_pulses = 0;
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(stat, 8'h00);
    chk(cfg, 8'h07);
    chk({dfast, ddual}, 8'h84);
    chk({4'h0, dquad}, 8'h06);
    host.send_frame({OP_WRITE_STATUS, 8'h8C, 8'h07}, 24);
    settle();
    chk(stat, 8'h00);
    wsr(8'h8F, 8'hF5, 24, 1'b1);
    chk(stat, 8'h8C);
    chk(cfg, 8'hC5);
    wp_n = 1'b0; // Lock already set, now pin low
    repeat (6) @(posedge clk);
    #1 chk({6'h00, sw, hw}, 8'h01);
    wsr(8'h00, 8'h07, 24, 1'b0);
    chk(stat & 8'hFC, 8'h8C);
    four = 1'b1;
    repeat (3) @(posedge clk);
    #1 chk({6'h00, sw, hw}, 8'h02);
    four = 1'b0;
    wp_n = 1'b1; // Pin held high for locked writes
    repeat (6) @(posedge clk);
    #1 chk({6'h00, sw, hw}, 8'h02);
    for (int i = 0; i < 4; i++) begin
      wsr(8'h8C, {i[1:0], 3'b000, drvs[i]}, 24, 1'b1);
      chk(cfg, {i[1:0], 3'b000, drvs[i]});
      chk({lvl, 1'b0, drv}, {4'h3, 1'b0, drvs[i]});
      chk({dfast, ddual}, {ft[i], dt[i]});
      chk({dquad, 3'h0, drsv}, {qt[i], 3'h0, rsv[i]});
    end
    wsr(8'h04, 8'hFF, 16, 1'b1);
    chk(stat, 8'h04);
    chk(cfg, 8'hC0);
    wsr(8'h00, 8'hFF, 20, 1'b0);
    chk(stat, 8'h06);
    pe_req = 1'b1;
    pe_reg = 1'b1;
    @(posedge clk);
    #1 pe_req = 1'b0;
    chk({7'h00, blk}, 8'h01);
    repeat (2) @(posedge clk);
    #1 chk(stat, 8'h04);
    wsr(8'h04, 8'h08, 24, 1'b1);
    wsr(8'h04, 8'h00, 24, 1'b1);
    chk({7'h00, orient}, 8'h01);
    chk(cfg, 8'h08);
    // Latch set, unprotected program granted, completion clears the latch
    host.send_frame(24'(OP_WRITE_ENABLE), 8);
    pe_reg = 1'b0;
    @(posedge clk) #1 pe_req = 1'b1;
    @(posedge clk) #1 pe_req = 1'b0;
    chk({6'h00, grt, stat[1]}, 8'h03);
    pe_done = 1'b1;
    @(posedge clk) #1 pe_done = 1'b0;
    chk(stat, 8'h04);
    // Quad enable with lock set: low pin must not lock
    wsr(8'hC0, 8'h08, 24, 1'b1);
    chk({6'h00, quad, stat[6]}, 8'h03);
    chk({nvs, 1'b0, nvo}, 8'hC1);
    chk(8'(nv_pulses), 8'h09);
    wp_n = 1'b0;
    repeat (6) @(posedge clk);
    #1 chk({6'h00, sw, hw}, 8'h02);
    complete_run();
  end
endmodule
